// ### src/sdp_defines.svh
// constants of the serial debug slave port
`ifndef SDP_DEFINES_SVH
`define SDP_DEFINES_SVH

`define SDP_CMD_W          8
`define SDP_WORD_W         16
`define SDP_CMD_WRITE      8'h02
`define SDP_CMD_READ       8'h03
`define SDP_CMD_LAST_BIT   4'h7
`define SDP_WORD_LAST_BIT  4'hF
`define SDP_CS_RESET_EDGES 2'h2
`define SDP_BUF_DEPTH      2
`define SDP_SYNC_W         3

`endif

// ### src/sdp_pkg.sv
// types shared by the serial debug slave port
`include "sdp_defines.svh"

package sdp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_WDATA,
        ST_RCHK,
        ST_RDATA,
        ST_IGNORE
    } sdp_state_t;

    typedef struct packed {
        logic [`SDP_WORD_W-1:0] addr;
        logic [`SDP_WORD_W-1:0] data;
    } sdp_wr_t;

endpackage

// ### src/sdp_buf2.sv
// small valid/ready buffer built from flip-flops
`timescale 1ns/1ns

module sdp_buf2 #(
    parameter int W = 32,
    parameter int D = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic      [W-1:0] out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_reg [D];
    logic [PW-1:0] wptr_reg;
    logic [PW-1:0] rptr_reg;
    logic [CW-1:0] count_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (count_reg != CW'(D));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rptr_reg];

    genvar i;
    generate
        for (i = 0; i < D; i++) begin : g_entry
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    mem_reg[i] <= '0;
                end else if (push && (wptr_reg == PW'(i))) begin
                    mem_reg[i] <= in_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == PW'(D - 1)) ? '0 : wptr_reg + PW'(1);
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == PW'(D - 1)) ? '0 : rptr_reg + PW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + CW'(1);
        end else if (pop && !push) begin
            count_reg <= count_reg - CW'(1);
        end
    end

endmodule

// ### src/sdp_slave.sv
// serial debug slave port: link front end, transaction engine, memory ports
`timescale 1ns/1ns
`include "sdp_defines.svh"

// Functional notes
// - select high two clocks resets port to idle
// - select low starts; capture 8-bit command
// - next 16 bits latched as start address
// - data then moves in 16-bit words
// - sample incoming data on rising serial clock
// - change outgoing data on falling serial clock
// - select high ends transfer, drops partial word
// - each further 16 clocks moves next word
// - command 00000010 means write
// - writes store words at consecutive addresses
// - command 00000011 means read
// - read sends check word, then location contents
// - check word is command and address high byte
// - read bursts return consecutive locations
// - deselected output driven: 0 running, 1 stopped
// - works whether processor runs or halts

module sdp_slave (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    spi_sclk,
    input  wire logic                    spi_cs_n,
    input  wire logic                    spi_mosi,
    output logic                         spi_miso,
    output logic                         spi_miso_oe,
    input  wire logic                    cpu_run,
    output sdp_pkg::sdp_wr_t             wr_out,
    output logic                         wr_valid,
    input  wire logic                    wr_ready,
    output logic [`SDP_WORD_W-1:0]       rd_addr,
    output logic                         rd_valid,
    input  wire logic                    rd_ready,
    input  wire logic [`SDP_WORD_W-1:0]  rd_data,
    input  wire logic                    rd_data_valid,
    output logic                         wr_overrun,
    output logic                         port_reset
);
    import sdp_pkg::*;

    logic [`SDP_SYNC_W-1:0] sync1_reg;
    logic [`SDP_SYNC_W-1:0] sync2_reg;
    logic                   sclk_prev_reg;
    logic                   sclk_s;
    logic                   cs_hi;
    logic                   mosi_s;
    logic                   sclk_rise;
    logic                   sclk_fall;

    sdp_state_t             state_reg;
    logic [3:0]             bit_cnt_reg;
    logic [`SDP_WORD_W-1:0] shift_reg;
    logic [`SDP_WORD_W-1:0] in_word;
    logic                   word_done;
    logic [`SDP_CMD_W-1:0]  cmd_reg;
    logic [`SDP_WORD_W-1:0] addr_reg;
    logic [`SDP_WORD_W-1:0] tx_reg;
    logic [`SDP_WORD_W-1:0] rd_hold_reg;
    logic [`SDP_WORD_W-1:0] rd_addr_reg;
    logic                   rd_valid_reg;
    logic                   miso_reg;
    logic [1:0]             rst_cnt_reg;
    logic                   port_reset_reg;
    logic                   overrun_reg;

    logic                   is_write;
    logic                   is_read;
    logic                   addr_done;
    logic                   rchk_done;
    logic                   rdata_done;
    logic                   wdata_done;
    logic                   push_valid;
    logic                   push_ready;
    sdp_wr_t                push_word;

    // two flip-flops on every pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // idle pin levels: clock low, select high, so no false clock edge follows reset
            sync1_reg <= 3'h2;
            sync2_reg <= 3'h2;
        end else begin
            sync1_reg <= {spi_sclk, spi_cs_n, spi_mosi};
            sync2_reg <= sync1_reg;
        end
    end

    assign sclk_s = sync2_reg[2];
    assign cs_hi  = sync2_reg[1];
    assign mosi_s = sync2_reg[0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_prev_reg <= 1'h0;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_prev_reg;
    assign sclk_fall = !sclk_s && sclk_prev_reg;

    // decoded events of the transaction
    assign in_word    = {shift_reg[`SDP_WORD_W-2:0], mosi_s};
    assign is_write   = (cmd_reg == `SDP_CMD_WRITE);
    assign is_read    = (cmd_reg == `SDP_CMD_READ);
    assign word_done  = (state_reg == ST_CMD) ? (bit_cnt_reg == `SDP_CMD_LAST_BIT)
                                              : (bit_cnt_reg == `SDP_WORD_LAST_BIT);
    assign addr_done  = sclk_rise && word_done && (state_reg == ST_ADDR) && !cs_hi;
    assign rchk_done  = sclk_rise && word_done && (state_reg == ST_RCHK) && !cs_hi;
    assign rdata_done = sclk_rise && word_done && (state_reg == ST_RDATA) && !cs_hi;
    assign wdata_done = sclk_rise && word_done && (state_reg == ST_WDATA) && !cs_hi;

    // transaction state; select high always wins and drops the partial word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else if (cs_hi) begin
            state_reg <= ST_IDLE;
        end else if (state_reg == ST_IDLE) begin
            state_reg <= ST_CMD;
        end else if (sclk_rise && word_done) begin
            unique case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_CMD;
                end
                ST_CMD: begin
                    state_reg <= ST_ADDR;
                end
                ST_ADDR: begin
                    if (is_write) begin
                        state_reg <= ST_WDATA;
                    end else if (is_read) begin
                        state_reg <= ST_RCHK;
                    end else begin
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_RCHK: begin
                    state_reg <= ST_RDATA;
                end
                ST_RDATA: begin
                    state_reg <= ST_RDATA;
                end
                ST_WDATA: begin
                    state_reg <= ST_WDATA;
                end
                ST_IGNORE: begin
                    state_reg <= ST_IGNORE;
                end
            endcase
        end
    end

    // bit counting and input shifting on rising serial clock edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 16'h0000;
        end else if (cs_hi) begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 16'h0000;
        end else if (sclk_rise && (state_reg != ST_IDLE)) begin
            shift_reg   <= in_word;
            bit_cnt_reg <= word_done ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end

    // command and address capture, auto increment per word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_reg  <= 8'h00;
            addr_reg <= 16'h0000;
        end else if (sclk_rise && word_done && (state_reg == ST_CMD) && !cs_hi) begin
            cmd_reg <= in_word[`SDP_CMD_W-1:0];
        end else if (addr_done) begin
            addr_reg <= in_word;
        end else if (wdata_done || rchk_done || rdata_done) begin
            addr_reg <= addr_reg + 16'h0001;
        end
    end

    // write words go to the buffer with the address they belong to
    assign push_word.addr = addr_reg;
    assign push_word.data = in_word;
    assign push_valid     = wdata_done;

    sdp_buf2 #(
        .W ($bits(sdp_wr_t)),
        .D (`SDP_BUF_DEPTH)
    ) u_wbuf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (push_word),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .out_data  (wr_out),
        .out_valid (wr_valid),
        .out_ready (wr_ready)
    );

    // the master cannot be stalled, so a word meeting a full buffer is flagged
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            overrun_reg <= 1'h0;
        end else if (push_valid && !push_ready) begin
            overrun_reg <= 1'h1;
        end
    end

    // read requests: first at the address, then one ahead of each data word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_addr_reg  <= 16'h0000;
            rd_valid_reg <= 1'h0;
        end else if (addr_done && is_read) begin
            rd_addr_reg  <= in_word;
            rd_valid_reg <= 1'h1;
        end else if (rchk_done || rdata_done) begin
            rd_addr_reg  <= addr_reg + 16'h0001;
            rd_valid_reg <= 1'h1;
        end else if (rd_ready) begin
            rd_valid_reg <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_hold_reg <= 16'h0000;
        end else if (rd_data_valid) begin
            rd_hold_reg <= rd_data;
        end
    end

    // outgoing word: check word after the address, then memory contents
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_reg <= 16'h0000;
        end else if (addr_done && is_read) begin
            tx_reg <= {cmd_reg, in_word[15:8]};
        end else if (rchk_done || rdata_done) begin
            tx_reg <= rd_hold_reg;
        end else if (sclk_fall && !cs_hi && ((state_reg == ST_RCHK) || (state_reg == ST_RDATA))) begin
            tx_reg <= {tx_reg[`SDP_WORD_W-2:0], 1'h0};
        end
    end

    // output pin always driven; level shows processor state while deselected
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            miso_reg <= 1'h0;
        end else if (cs_hi) begin
            miso_reg <= !cpu_run;
        end else if (sclk_fall && ((state_reg == ST_RCHK) || (state_reg == ST_RDATA))) begin
            miso_reg <= tx_reg[`SDP_WORD_W-1];
        end
    end

    // count serial clocks seen with select high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_cnt_reg    <= 2'h0;
            port_reset_reg <= 1'h0;
        end else if (!cs_hi) begin
            rst_cnt_reg    <= 2'h0;
            port_reset_reg <= 1'h0;
        end else if (sclk_rise && (rst_cnt_reg != `SDP_CS_RESET_EDGES)) begin
            rst_cnt_reg    <= rst_cnt_reg + 2'h1;
            port_reset_reg <= (rst_cnt_reg + 2'h1 == `SDP_CS_RESET_EDGES);
        end else begin
            port_reset_reg <= 1'h0;
        end
    end

    // no path depends on cpu_run except the idle level, so access works either way
    assign spi_miso    = miso_reg;
    assign spi_miso_oe = 1'h1;
    assign rd_addr     = rd_addr_reg;
    assign rd_valid    = rd_valid_reg;
    assign wr_overrun  = overrun_reg;
    assign port_reset  = port_reset_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_idle: assert property (
        port_reset |-> (state_reg == ST_IDLE) && (bit_cnt_reg == 4'h0))
        else $error("port reset seen but engine not idle");

    a_cmd_capture: assert property (
        (sclk_rise && !cs_hi && (state_reg == ST_CMD) && (bit_cnt_reg == 4'h7))
        |=> (cmd_reg == $past(in_word[7:0])) && (state_reg == ST_ADDR || cs_hi))
        else $error("command byte not captured after eight bits");

    a_addr_latch: assert property (
        addr_done |=> (addr_reg == $past(in_word)))
        else $error("address word not latched");

    a_word_len: assert property (
        (sclk_rise && !cs_hi && (state_reg inside {ST_ADDR, ST_WDATA, ST_RDATA})
         && (bit_cnt_reg != 4'hF)) |=> (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1))
        else $error("bit counter skipped within a word");

    a_mosi_rise: assert property (
        (!sclk_rise && !cs_hi && !$past(cs_hi)) |=> $stable(shift_reg))
        else $error("input shifted without rising serial clock");

    a_miso_fall: assert property (
        (!sclk_fall && !cs_hi) |=> $stable(spi_miso) || $past(cs_hi) || cs_hi)
        else $error("output changed away from falling serial clock");

    a_cs_abort: assert property (
        cs_hi |=> (state_reg == ST_IDLE) && (bit_cnt_reg == 4'h0) && !wdata_done)
        else $error("select high did not end the transaction");

    a_wr_incr: assert property (
        wdata_done && push_ready |=> wr_valid && (addr_reg == $past(addr_reg) + 16'h0001))
        else $error("write word not queued or address not advanced");

    a_wr_decode: assert property (
        (addr_done && is_write) |=> (state_reg == ST_WDATA) || cs_hi)
        else $error("write command not decoded");

    a_rd_decode: assert property (
        (addr_done && is_read) |=> (state_reg == ST_RCHK) && rd_valid)
        else $error("read command not decoded");

    a_check_word: assert property (
        (addr_done && is_read) |=> (tx_reg == {cmd_reg, addr_reg[15:8]}))
        else $error("check word malformed");

    a_rd_next: assert property (
        rdata_done |=> rd_valid && (rd_addr == $past(addr_reg) + 16'h0001)
                        && (tx_reg == $past(rd_hold_reg)))
        else $error("burst read did not move to next location");

    a_idle_drive: assert property (
        (cs_hi && $past(cs_hi)) |=> spi_miso_oe && (spi_miso == !$past(cpu_run)))
        else $error("deselected output level wrong");

    a_bad_cmd: assert property (
        (state_reg == ST_IGNORE) |-> !is_write && !is_read && !wdata_done && !rchk_done && !rdata_done)
        else $error("unknown command moved data");

    c_write: cover property (wdata_done ##[1:300] wdata_done);
    c_read: cover property (rchk_done ##[1:300] rdata_done);
    c_ignore: cover property (state_reg == ST_IGNORE);
    c_reset: cover property (port_reset);

endmodule

// ### tb/sdp_master_model.sv
// serial master model that drives the debug slave port link
`timescale 1ns/1ns

module sdp_master_model (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // sclk runs only here and in shift, otherwise it stands low
    task automatic link_reset();
        for (int i = 0; i < 2; i++) begin
            wait_clk(4);
            sclk <= 1'b1;
            wait_clk(4);
            sclk <= 1'b0;
        end
        wait_clk(4);
    endtask

    task automatic start();
        @(posedge clk);
        cs_n <= 1'b0;
        wait_clk(4);
    endtask

    // mosi changes with the falling edge, miso is read late in the high phase
    task automatic shift(input logic [15:0] v, input int n, output logic [15:0] r);
        r = 16'h0000;
        for (int i = 15; i > 15 - n; i--) begin
            mosi <= v[i];
            wait_clk(4);
            sclk <= 1'b1;
            wait_clk(4);
            r = {r[14:0], miso};
            sclk <= 1'b0;
        end
    endtask

    // released data line shows the inverse of its last level
    task automatic stop();
        wait_clk(4);
        cs_n <= 1'b1;
        mosi <= ~mosi;
        wait_clk(4);
    endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the serial debug slave port
`timescale 1ns/1ns
`include "sdp_defines.svh"

module tb_top;
    import sdp_pkg::*;

    typedef struct packed {
        logic        run;
        logic [15:0] addr;
        logic [15:0] d0;
        logic [15:0] d1;
    } sdp_row_t;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cpu_run = 1'b1;
    logic        wr_ready = 1'b1;
    logic [15:0] rd_data = 16'h0000;
    logic        rd_data_valid = 1'b0;
    logic        sclk, cs_n, mosi, miso, miso_oe;
    logic        wr_valid, rd_valid, wr_overrun, port_reset;
    sdp_wr_t     wr_out;
    logic [15:0] rd_addr, rd_pend, r;
    logic [15:0] mem [logic [15:0]];
    logic        wr_stall = 1'b0;
    int          wr_cnt = 0, rd_cnt = 0, rst_seen = 0, rd_wait = 0, cyc = 0, n0, n1;
    int          err_total = 0;
    int          tests_run = 0;
    sdp_row_t    rows [3] = '{
        '{1'b1, 16'h1234, 16'hA55A, 16'h0FF0},
        '{1'b0, 16'h00FF, 16'h8001, 16'h7FFE},
        '{1'b1, 16'hFF00, 16'hFFFF, 16'h0000}};

    always #25 clk = ~clk;

    sdp_master_model i_sdp_master_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    sdp_slave i_sdp_slave (
        .clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe(miso_oe), .cpu_run(cpu_run), .wr_out(wr_out),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_ready(1'b1), .rd_data(rd_data), .rd_data_valid(rd_data_valid),
        .wr_overrun(wr_overrun), .port_reset(port_reset));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // memory side: stallable write sink, read answered a few clocks later
    always @(posedge clk) begin
        wr_ready <= !wr_stall;
        rd_data_valid <= 1'b0;
        if (wr_valid && wr_ready) begin
            mem[wr_out.addr] = wr_out.data;
            wr_cnt++;
        end
        if (rd_valid) begin
            rd_pend = rd_addr;
            rd_wait = 3;
            rd_cnt++;
        end else if (rd_wait > 0) begin
            rd_wait--;
            if (rd_wait == 0) begin
                rd_data <= mem.exists(rd_pend) ? mem[rd_pend] : 16'hDEAD;
                rd_data_valid <= 1'b1;
            end
        end
        if (port_reset) rst_seen++;
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    // one frame: command, address, whole words, then a cut word of tail bits
    task automatic send(input logic [7:0] c, input logic [15:0] a, input logic [15:0] w[$], input int tail);
        i_sdp_master_model.start();
        i_sdp_master_model.shift({c, 8'h00}, 8, r);
        i_sdp_master_model.shift(a, 16, r);
        foreach (w[i]) i_sdp_master_model.shift(w[i], 16, r);
        if (tail > 0) i_sdp_master_model.shift(16'hC3C3, tail, r);
        i_sdp_master_model.stop();
        repeat (8) @(posedge clk);
    endtask

    task automatic rd_check(input sdp_row_t w);
        i_sdp_master_model.start();
        i_sdp_master_model.shift({`SDP_CMD_READ, 8'h00}, 8, r);
        i_sdp_master_model.shift(w.addr, 16, r);
        i_sdp_master_model.shift(16'h0000, 16, r);
        chk_word("check word", {`SDP_CMD_READ, w.addr[15:8]}, r);
        i_sdp_master_model.shift(16'h0000, 16, r);
        chk_word("read word 0", w.d0, r);
        i_sdp_master_model.shift(16'h0000, 16, r);
        chk_word("read word 1", w.d1, r);
        i_sdp_master_model.stop();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit("miso in reset", 1'b0, miso);
        chk_bit("miso driven", 1'b1, miso_oe);
        chk_bit("wr_valid in reset", 1'b0, wr_valid);
        chk_bit("overrun in reset", 1'b0, wr_overrun);
        @(posedge clk);
        rst_n <= 1'b1;
        // a single clock with select high must not reset the port yet
        i_sdp_master_model.shift(16'h0000, 1, r);
        chk_word("one clock no reset", 16'h0000, 16'(rst_seen));
        i_sdp_master_model.link_reset();
        chk_word("port reset pulses", 16'h0001, 16'(rst_seen));
        foreach (rows[k]) begin
            cpu_run <= rows[k].run;
            repeat (8) @(posedge clk);
            chk_bit("idle miso", !rows[k].run, miso);
            send(`SDP_CMD_WRITE, rows[k].addr, {rows[k].d0, rows[k].d1}, 0);
            chk_word("mem first", rows[k].d0, mem[rows[k].addr]);
            chk_word("mem next", rows[k].d1, mem[rows[k].addr + 16'h0001]);
            rd_check(rows[k]);
        end
        // command cut short, then link reset and a clean write
        i_sdp_master_model.start();
        i_sdp_master_model.shift({`SDP_CMD_WRITE, 8'h00}, 5, r);
        i_sdp_master_model.stop();
        i_sdp_master_model.link_reset();
        chk_word("port reset again", 16'h0002, 16'(rst_seen));
        send(`SDP_CMD_WRITE, 16'h2000, {16'h5AA5}, 0);
        chk_word("write after abort", 16'h5AA5, mem[16'h2000]);
        n0 = wr_cnt;
        send(`SDP_CMD_WRITE, 16'h3000, {16'h1234}, 7);
        chk_word("partial word writes", 16'h0001, 16'(wr_cnt - n0));
        chk_word("whole word kept", 16'h1234, mem[16'h3000]);
        n0 = wr_cnt;
        n1 = rd_cnt;
        send(8'h05, 16'h3001, {16'h1111, 16'h2222}, 0);
        chk_word("unknown cmd writes", 16'h0000, 16'(wr_cnt - n0));
        chk_word("unknown cmd reads", 16'h0000, 16'(rd_cnt - n1));
        // stalled sink: two words wait in the buffer, the third overflows
        wr_stall <= 1'b1;
        n0 = wr_cnt;
        send(`SDP_CMD_WRITE, 16'h4000, {16'h1111, 16'h2222, 16'h3333}, 0);
        chk_bit("held while stalled", 1'b1, wr_valid);
        chk_bit("overrun flagged", 1'b1, wr_overrun);
        wr_stall <= 1'b0;
        repeat (20) @(posedge clk);
        chk_word("buffered writes", 16'h0002, 16'(wr_cnt - n0));
        chk_word("buffered first", 16'h1111, mem[16'h4000]);
        chk_word("buffered second", 16'h2222, mem[16'h4001]);
        chk_bit("buffer drained", 1'b0, wr_valid);
        end_sim();
    end
endmodule
